// ---- state_save_pkg.sv ----
// shared constants for the state save optimizer
`default_nettype none
package state_save_pkg;
   // bitmap geometry
   localparam int          COMP_W        = 64;
   localparam int          LAST_COMP     = 62;
   localparam int          PRESENCE_TOP  = 63;
   localparam int          VEC_COMP      = 1;
   localparam int          WIDE_VEC_COMP = 2;
   // save area alignment, 64 bytes
   localparam int          ALIGN_BITS    = 6;
   localparam logic [5:0]  ALIGN_ZERO    = 6'h00;
   // privilege level at which alignment checking may apply
   localparam logic [1:0]  USER_PRIV     = 2'h3;
   // values after reset
   localparam logic [63:0] INUSE_RST     = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] MODIFIED_RST  = 64'hFFFF_FFFF_FFFF_FFFF;
   // top bit set: no restore seen yet, so no skip on unmodified state
   localparam logic [63:0] RECORD_CMP_RST = 64'h8000_0000_0000_0000;
   localparam logic [63:0] ALL_ZERO      = 64'h0000_0000_0000_0000;
   localparam logic [1:0]  PRIV_RST      = 2'h0;
endpackage
`default_nettype wire

// ---- save_fault_check.sv ----
// fault screening for the optimized save
`timescale 1ns/1ps
`default_nettype none
module save_fault_check #(
   parameter bit AC_INSTEAD = 1'b1
) (
   // core controls
   input  wire logic       osSaveEnable,
   input  wire logic       taskSwitched,
   input  wire logic       alignMaskCtrl,
   input  wire logic       flagsAlignCheck,
   input  wire logic [1:0] privLevel,
   input  wire logic [5:0] areaAddrLow,
   // fault verdicts, one hot at most
   output logic            invalidOpcodeFault,
   output logic            deviceUnavailableFault,
   output logic            generalProtectionFault,
   output logic            alignmentCheckFault
);
   logic misaligned;
   logic acChosen;

   always_comb
   begin
      misaligned = (areaAddrLow != state_save_pkg::ALIGN_ZERO);
      acChosen   = AC_INSTEAD && alignMaskCtrl && flagsAlignCheck
                   && (privLevel == state_save_pkg::USER_PRIV);
      // priority: disabled feature, then lazy switch, then alignment
      invalidOpcodeFault     = !osSaveEnable;
      deviceUnavailableFault = osSaveEnable && taskSwitched;
      generalProtectionFault = osSaveEnable && !taskSwitched
                               && misaligned && !acChosen;
      alignmentCheckFault    = osSaveEnable && !taskSwitched
                               && misaligned && acChosen;
   end
endmodule
`default_nettype wire

// ---- tracking_bitmaps.sv ----
// per-component in-use and modified tracking
`timescale 1ns/1ps
`default_nettype none
module tracking_bitmaps #(
   parameter int          COMP_W     = 64,
   parameter logic [63:0] INIT_TRACK = 64'h7FFF_FFFF_FFFF_FFFF,
   parameter logic [63:0] MOD_TRACK  = 64'h7FFF_FFFF_FFFF_FFFF
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // restore update
   input  wire logic              restoreReq,
   input  wire logic [COMP_W-1:0] requested_component_mask,
   input  wire logic [COMP_W-1:0] headerPresenceIn,
   // core activity
   input  wire logic [COMP_W-1:0] compUsed,
   input  wire logic [COMP_W-1:0] compWritten,
   // bitmaps
   output logic      [COMP_W-1:0] componentInuseBitmap,
   output logic      [COMP_W-1:0] componentModifiedBitmap
);
   genvar i;
   generate
      for (i = 0; i < COMP_W; i++)
      begin : g_comp
         // core activity wins over a restore in the same cycle
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               componentInuseBitmap[i] <= state_save_pkg::INUSE_RST[i];
            else if (compUsed[i])
               componentInuseBitmap[i] <= 1'b1;
            else if (restoreReq && requested_component_mask[i])
               componentInuseBitmap[i] <= headerPresenceIn[i] | ~INIT_TRACK[i];
         end

         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
               componentModifiedBitmap[i] <= state_save_pkg::MODIFIED_RST[i];
            else if (compWritten[i])
               componentModifiedBitmap[i] <= 1'b1;
            else if (restoreReq)
               componentModifiedBitmap[i] <= ~requested_component_mask[i] | ~MOD_TRACK[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- state_save_optimizer.sv ----
// restore tracking and optimized save decision logic
`timescale 1ns/1ps
`default_nettype none
// Operation
// - restore mask is enables AND operand
// - unrequested restore keeps in-use bit
// - absent presence: in-use may clear
// - requested and present sets in-use
// - unrequested restore marks component modified
// - requested restore may clear modified bit
// - restore records privilege, guest, address, compaction
// - standard form records zero compaction
// - empty mask: only modified bits set
// - save mask is enables AND operand
// - save disabled gives invalid opcode
// - task switched gives device unavailable
// - misaligned area gives protection fault
// - alignment check may replace protection fault
// - presence rewritten from in-use where requested
// - presence bit one ignores control status
// - save never writes compaction field
// - legacy and standard extended layout
// - skip components not in use
// - modified skip needs matching record
// - skip unmodified components when allowed
// - control status saved with bit one or two
// - skips never drop control status
module state_save_optimizer #(
   parameter int          COMP_W     = 64,
   parameter int          ADDR_W     = 64,
   parameter bit          AC_INSTEAD = 1'b1,
   parameter logic [63:0] INIT_TRACK = 64'h7FFF_FFFF_FFFF_FFFF,
   parameter logic [63:0] MOD_TRACK  = 64'h7FFF_FFFF_FFFF_FFFF
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // architectural controls
   input  wire logic [COMP_W-1:0] featureEnableRegister,
   input  wire logic [COMP_W-1:0] maskRegisterPair,
   input  wire logic              osSaveEnableBit,
   input  wire logic              taskSwitchedFlag,
   input  wire logic              alignmentMaskControl,
   input  wire logic              flagsAlignmentCheckBit,
   input  wire logic [1:0]        currentPrivilegeLevel,
   input  wire logic              virtualizedGuestMode,
   input  wire logic [ADDR_W-1:0] saveAreaAddr,
   // operation requests and header read from the save area
   input  wire logic              restoreReq,
   input  wire logic              saveReq,
   input  wire logic [COMP_W-1:0] headerPresenceBits,
   input  wire logic [COMP_W-1:0] headerCompactionBits,
   // core state activity
   input  wire logic [COMP_W-1:0] compUsed,
   input  wire logic [COMP_W-1:0] compWritten,
   // tracking state
   output logic      [COMP_W-1:0] componentInuseBitmap,
   output logic      [COMP_W-1:0] componentModifiedBitmap,
   output logic                   restoreDone,
   // save results
   output logic                   saveDone,
   output logic      [COMP_W-1:0] presenceWriteValue,
   output logic      [COMP_W-1:0] componentWriteMask,
   output logic                   saveVectorControlStatus,
   output logic                   modifiedOptUsed,
   // save faults
   output logic                   invalidOpcodeFault,
   output logic                   deviceUnavailableFault,
   output logic                   generalProtectionFault,
   output logic                   alignmentCheckFault
);
   generate
      if (COMP_W != 64)
         $error("component bitmap must be 64 bits wide");
      if (ADDR_W < state_save_pkg::ALIGN_BITS + 1)
         $error("save area address too narrow");
   endgenerate

   logic [COMP_W-1:0] requestedComponentMask;
   logic              udNow;
   logic              nmNow;
   logic              gpNow;
   logic              acNow;
   logic              anyFault;
   logic              recordMatch;
   logic [COMP_W-1:0] next_writeMask;
   logic [COMP_W-1:0] next_presence;

   // last restore record
   logic [1:0]        recPriv;
   logic              recGuest;
   logic [ADDR_W-1:0] recAddr;
   logic [COMP_W-1:0] recCompaction;

   // one mask serves both operations
   assign requestedComponentMask = featureEnableRegister & maskRegisterPair;

   save_fault_check #(
      .AC_INSTEAD(AC_INSTEAD)
   ) u_faults (
      .osSaveEnable          (osSaveEnableBit),
      .taskSwitched          (taskSwitchedFlag),
      .alignMaskCtrl         (alignmentMaskControl),
      .flagsAlignCheck       (flagsAlignmentCheckBit),
      .privLevel             (currentPrivilegeLevel),
      .areaAddrLow           (saveAreaAddr[5:0]),
      .invalidOpcodeFault    (udNow),
      .deviceUnavailableFault(nmNow),
      .generalProtectionFault(gpNow),
      .alignmentCheckFault   (acNow)
   );

   tracking_bitmaps #(
      .COMP_W    (COMP_W),
      .INIT_TRACK(INIT_TRACK),
      .MOD_TRACK (MOD_TRACK)
   ) u_track (
      .clk_sys                (clk_sys),
      .rst_n                  (rst_n),
      .restoreReq             (restoreReq),
      .requested_component_mask                   (requestedComponentMask),
      .headerPresenceIn       (headerPresenceBits),
      .compUsed               (compUsed),
      .compWritten            (compWritten),
      .componentInuseBitmap   (componentInuseBitmap),
      .componentModifiedBitmap(componentModifiedBitmap)
   );

   assign anyFault = udNow | nmNow | gpNow | acNow;

   // restore record; held until the next restore
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         recPriv       <= state_save_pkg::PRIV_RST;
         recGuest      <= 1'b0;
         recAddr       <= '0;
         recCompaction <= state_save_pkg::RECORD_CMP_RST;
      end
      else if (restoreReq)
      begin
         recPriv  <= currentPrivilegeLevel;
         recGuest <= virtualizedGuestMode;
         recAddr  <= saveAreaAddr;
         // standard form leaves the whole field zero
         if (headerCompactionBits[state_save_pkg::PRESENCE_TOP])
            recCompaction <= headerCompactionBits;
         else
            recCompaction <= state_save_pkg::ALL_ZERO;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         restoreDone <= 1'b0;
      else
         restoreDone <= restoreReq;
   end

   // save decision
   always_comb
   begin
      recordMatch = (recPriv == currentPrivilegeLevel)
                    && (recGuest == virtualizedGuestMode)
                    && (recAddr == saveAreaAddr)
                    && (recCompaction == state_save_pkg::ALL_ZERO);
      // legacy 0..1 and standard extended 2..62; never the top bit
      next_writeMask = requestedComponentMask
                       & componentInuseBitmap
                       & ~({COMP_W{recordMatch}} & ~componentModifiedBitmap);
      next_writeMask[state_save_pkg::PRESENCE_TOP] = 1'b0;
      // bit 1 follows vector registers only, not the control word
      next_presence = (headerPresenceBits & ~requestedComponentMask)
                      | (componentInuseBitmap & requestedComponentMask);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         saveDone                <= 1'b0;
         presenceWriteValue      <= '0;
         componentWriteMask      <= '0;
         saveVectorControlStatus <= 1'b0;
         modifiedOptUsed         <= 1'b0;
      end
      else
      begin
         saveDone <= saveReq && !anyFault;
         if (saveReq && !anyFault)
         begin
            presenceWriteValue <= next_presence;
            componentWriteMask <= next_writeMask;
            // control word escapes both skips
            saveVectorControlStatus <=
               requestedComponentMask[state_save_pkg::VEC_COMP]
               | requestedComponentMask[state_save_pkg::WIDE_VEC_COMP];
            modifiedOptUsed <= recordMatch;
         end
      end
   end
   // only the presence value is offered to memory; compaction has no port

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         invalidOpcodeFault     <= 1'b0;
         deviceUnavailableFault <= 1'b0;
         generalProtectionFault <= 1'b0;
         alignmentCheckFault    <= 1'b0;
      end
      else
      begin
         invalidOpcodeFault     <= saveReq && udNow;
         deviceUnavailableFault <= saveReq && nmNow;
         generalProtectionFault <= saveReq && gpNow;
         alignmentCheckFault    <= saveReq && acNow;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence sSaveIssued;
      saveReq && osSaveEnableBit && !taskSwitchedFlag;
   endsequence

   sequence sSaveClean;
      sSaveIssued ##0 (saveAreaAddr[5:0] == 6'h00);
   endsequence

   sequence sQuietRestore;
      restoreReq && (compUsed == '0) && (compWritten == '0);
   endsequence

   a_ud_raised: assert property (
      saveReq && !osSaveEnableBit |=> invalidOpcodeFault && !saveDone)
      else $error("disabled save did not raise invalid opcode");

   a_nm_raised: assert property (
      saveReq && osSaveEnableBit && taskSwitchedFlag
      |=> deviceUnavailableFault && !invalidOpcodeFault && !saveDone)
      else $error("task switched save did not raise device fault");

   a_align_fault: assert property (
      sSaveIssued ##0 (saveAreaAddr[5:0] != 6'h00)
      |=> (generalProtectionFault ^ alignmentCheckFault) && !saveDone)
      else $error("misaligned save not refused");

   a_ac_cause: assert property (
      alignmentCheckFault |-> $past(alignmentMaskControl && flagsAlignmentCheckBit
                                    && currentPrivilegeLevel == 2'h3))
      else $error("alignment check fault without its cause");

   a_save_done: assert property (
      sSaveClean |=> saveDone
      ##1 (!saveDone || $past(saveReq)))
      else $error("clean save did not complete in one cycle");

   a_presence_keep: assert property (
      saveDone |-> ((presenceWriteValue ^ $past(headerPresenceBits))
                    & ~$past(requestedComponentMask)) == '0)
      else $error("unrequested presence bit changed");

   a_presence_take: assert property (
      saveDone |-> ((presenceWriteValue ^ $past(componentInuseBitmap))
                    & $past(requestedComponentMask)) == '0)
      else $error("requested presence bit not from in-use");

   a_init_skip: assert property (
      saveDone |-> (componentWriteMask & ~$past(componentInuseBitmap)) == '0)
      else $error("component not in use was written");

   a_mod_skip: assert property (
      saveDone && modifiedOptUsed
      |-> (componentWriteMask & ~$past(componentModifiedBitmap)) == '0)
      else $error("unmodified component written");

   a_mod_gate: assert property (
      saveDone && modifiedOptUsed |-> $past(recCompaction) == '0
      && $past(recAddr) == $past(saveAreaAddr))
      else $error("modified skip used with stale record");

   a_unreq_none: assert property (
      saveDone |-> (componentWriteMask & ~$past(requestedComponentMask)) == '0
      && !componentWriteMask[63])
      else $error("write mask outside requested components");

   a_csr_kept: assert property (
      saveDone |-> saveVectorControlStatus
      == ($past(requestedComponentMask[1]) || $past(requestedComponentMask[2])))
      else $error("control status save decision wrong");

   a_inuse_held: assert property (
      sQuietRestore |=> ((componentInuseBitmap ^ $past(componentInuseBitmap))
                         & ~$past(requestedComponentMask)) == '0)
      else $error("unrequested in-use bit changed");

   a_inuse_set: assert property (
      restoreReq |=> (~componentInuseBitmap
                      & $past(requestedComponentMask & headerPresenceBits)) == '0)
      else $error("present component not marked in use");

   a_mod_marked: assert property (
      restoreReq |=> (~componentModifiedBitmap
                      & ~$past(requestedComponentMask)) == '0)
      else $error("unrequested component not marked modified");

   a_empty_mask: assert property (
      sQuietRestore ##0 (requestedComponentMask == '0)
      |=> componentInuseBitmap == $past(componentInuseBitmap)
      && (&componentModifiedBitmap))
      else $error("empty restore changed tracking wrongly");

   a_record_std: assert property (
      restoreReq && !headerCompactionBits[63] |=> recCompaction == '0
      ##1 (recCompaction == '0 || $past(restoreReq)))
      else $error("standard restore left nonzero compaction");

   a_record_hold: assert property (
      !restoreReq |=> $stable(recAddr) && $stable(recPriv) && $stable(recGuest))
      else $error("restore record changed without restore");

   a_record_take: assert property (
      restoreReq |=> recAddr == $past(saveAreaAddr)
      && recPriv == $past(currentPrivilegeLevel)
      && recGuest == $past(virtualizedGuestMode))
      else $error("restore record not captured");

   a_untracked_held: assert property (
      (componentInuseBitmap | INIT_TRACK) == '1 && (componentModifiedBitmap | MOD_TRACK) == '1)
      else $error("untracked component bit left clear");

   a_restore_done: assert property (
      restoreReq |=> restoreDone)
      else $error("restore did not complete in one cycle");
endmodule
`default_nettype wire

// ---- save_area_model.sv ----
// save area header model: presence and compaction words
`timescale 1ns/1ps
`default_nettype none
module save_area_model (
   // clock
   input  wire logic        clk_sys,
   // software preload of the header
   input  wire logic        loadEn,
   input  wire logic [63:0] loadPresence,
   input  wire logic [63:0] loadCompaction,
   // requests and write-back from the optimizer
   input  wire logic        restoreReq,
   input  wire logic        saveReq,
   input  wire logic        saveDone,
   input  wire logic [63:0] presenceWriteValue,
   // header as read, and as stored
   output logic      [63:0] headerPresenceBits,
   output logic      [63:0] headerCompactionBits,
   output logic      [63:0] storedPresence,
   output logic      [63:0] storedCompaction
);
   logic readOn;
   assign readOn = restoreReq | saveReq;
   // outside a read the lines show garbage, so a stale sample gets caught
   assign headerPresenceBits   = readOn ? storedPresence : ~storedPresence;
   assign headerCompactionBits = readOn ? storedCompaction : ~storedCompaction;
   always_ff @(posedge clk_sys)
   begin
      if (loadEn)
      begin
         storedPresence   <= loadPresence;
         storedCompaction <= loadCompaction;
      end
      else if (saveDone)
         storedPresence <= presenceWriteValue;
   end
endmodule
`default_nettype wire

// ---- state_save_optimizer_tb.sv ----
// self-checking bench for the state save optimizer
`timescale 1ns/1ps
`default_nettype none
module state_save_optimizer_tb;
   localparam logic [63:0] TRK  = 64'h7FFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] BASE = 64'h0000_1234_5678_9A00;
   localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
   logic        clk_sys, rst_n, restoreReq, saveReq, loadEn;
   logic        osSaveEnableBit, taskSwitchedFlag, alignmentMaskControl;
   logic        flagsAlignmentCheckBit, virtualizedGuestMode;
   logic [1:0]  currentPrivilegeLevel;
   logic [63:0] featureEnableRegister, maskRegisterPair, saveAreaAddr;
   logic [63:0] compUsed, compWritten, loadPresence, loadCompaction;
   logic [63:0] headerPresenceBits, headerCompactionBits, storedPresence, storedCompaction;
   logic [63:0] componentInuseBitmap, componentModifiedBitmap, presenceWriteValue, componentWriteMask;
   logic        restoreDone, saveDone, saveVectorControlStatus, modifiedOptUsed;
   logic        invalidOpcodeFault, deviceUnavailableFault, generalProtectionFault, alignmentCheckFault;
   logic [63:0] mIn, mMod, rAddr, rCmp, ePwv, eCwm, memP, memC;
   logic [1:0]  rPriv;
   logic        rGuest, eVcs, eOpt;
   int          errors, samplesChecked;
   // fault rows: expected {ud,nm,gp,ac}, then {os,ts,am,ac}, then {priv,addr[5:0]}
   logic [15:0] rows [8] = '{16'h8401, 16'h8000, 16'h4C01, 16'h2801,
                             16'h1BE0, 16'h2BBF, 16'h2AC8, 16'h08C0};

   state_save_optimizer #(.INIT_TRACK(TRK), .MOD_TRACK(TRK)) dut_u (
      .clk_sys, .rst_n, .featureEnableRegister, .maskRegisterPair, .osSaveEnableBit,
      .taskSwitchedFlag, .alignmentMaskControl, .flagsAlignmentCheckBit, .currentPrivilegeLevel,
      .virtualizedGuestMode, .saveAreaAddr, .restoreReq, .saveReq, .headerPresenceBits,
      .headerCompactionBits, .compUsed, .compWritten, .componentInuseBitmap,
      .componentModifiedBitmap, .restoreDone, .saveDone, .presenceWriteValue,
      .componentWriteMask, .saveVectorControlStatus, .modifiedOptUsed, .invalidOpcodeFault,
      .deviceUnavailableFault, .generalProtectionFault, .alignmentCheckFault);

   save_area_model mem_u (
      .clk_sys, .loadEn, .loadPresence, .loadCompaction, .restoreReq, .saveReq, .saveDone,
      .presenceWriteValue, .headerPresenceBits, .headerCompactionBits, .storedPresence,
      .storedCompaction);

   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic printVerdict();
      $display("errors %0d samplesChecked %0d", errors, samplesChecked);
      if (errors == 0 && samplesChecked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic modelSave();
      logic [63:0] r;
      r = featureEnableRegister & maskRegisterPair;
      eOpt = (rPriv === currentPrivilegeLevel) && (rGuest === virtualizedGuestMode)
             && (rAddr === saveAreaAddr) && (rCmp === 64'h0000_0000_0000_0000);
      eCwm = r & mIn & (eOpt ? mMod : ONES) & TRK;
      eVcs = r[1] | r[2];
      ePwv = (memP & ~r) | (mIn & r);
      memP = ePwv;
   endtask

   task automatic modelRestore(input logic [63:0] p);
      logic [63:0] r;
      r = featureEnableRegister & maskRegisterPair;
      mIn = (mIn & ~r) | (r & p) | (r & ~TRK);
      mMod = ~r | ~TRK;
      rPriv = currentPrivilegeLevel;
      rGuest = virtualizedGuestMode;
      rAddr = saveAreaAddr;
      rCmp = memC[63] ? memC : 64'h0000_0000_0000_0000;
   endtask

   // request, look at the answer one cycle later, then at the memory write-back
   task automatic op(input bit sv, input bit rs, input logic [3:0] f);
      logic [63:0] p;
      p = memP;
      @(posedge clk_sys);
      saveReq    <= sv;
      restoreReq <= rs;
      @(posedge clk_sys);
      saveReq    <= 1'b0;
      restoreReq <= 1'b0;
      #1;
      if (sv && f == 4'h0)
         modelSave();
      if (rs)
         modelRestore(p);
      check("faults", 64'({invalidOpcodeFault, deviceUnavailableFault, generalProtectionFault,
                          alignmentCheckFault}), 64'(f));
      check("restoreDone", 64'(restoreDone), 64'(rs));
      check("saveDone", 64'(saveDone), 64'(sv && f == 4'h0));
      check("writeMask", componentWriteMask, eCwm);
      check("presenceOut", presenceWriteValue, ePwv);
      check("ctrlStatus", 64'(saveVectorControlStatus), 64'(eVcs));
      check("modOpt", 64'(modifiedOptUsed), 64'(eOpt));
      check("inuse", componentInuseBitmap, mIn);
      check("modified", componentModifiedBitmap, mMod);
      @(posedge clk_sys);
      #1;
      check("memPresence", storedPresence, memP);
      check("memCompaction", storedCompaction, memC);
   endtask

   task automatic touch(input logic [63:0] u, input logic [63:0] w);
      @(posedge clk_sys);
      compUsed    <= u;
      compWritten <= w;
      @(posedge clk_sys);
      compUsed    <= 64'h0000_0000_0000_0000;
      compWritten <= 64'h0000_0000_0000_0000;
      mIn = mIn | u;
      mMod = mMod | w;
   endtask

   task automatic load(input logic [63:0] p, input logic [63:0] c);
      @(posedge clk_sys);
      loadEn         <= 1'b1;
      loadPresence   <= p;
      loadCompaction <= c;
      @(posedge clk_sys);
      loadEn <= 1'b0;
      memP = p;
      memC = c;
   endtask

   task automatic doReset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      mIn = state_save_pkg::INUSE_RST;
      mMod = state_save_pkg::MODIFIED_RST;
      rCmp = state_save_pkg::RECORD_CMP_RST;
      rPriv = state_save_pkg::PRIV_RST;
      {rGuest, eVcs, eOpt} = 3'h0;
      {rAddr, eCwm, ePwv} = {3{state_save_pkg::ALL_ZERO}};
      #1;
      check("inuseRst", componentInuseBitmap, state_save_pkg::INUSE_RST);
      check("modifiedRst", componentModifiedBitmap, state_save_pkg::MODIFIED_RST);
   endtask

   initial
   begin
      #200000;
      errors++;
      printVerdict();
   end

   initial
   begin
      {rst_n, restoreReq, saveReq, loadEn, taskSwitchedFlag, alignmentMaskControl} = 6'h00;
      {flagsAlignmentCheckBit, virtualizedGuestMode, currentPrivilegeLevel} = 4'h0;
      osSaveEnableBit = 1'b1;
      featureEnableRegister = 64'h8000_0000_0000_00FF;
      maskRegisterPair = 64'hFFFF_0000_0000_00F7;
      saveAreaAddr = BASE;
      {compUsed, compWritten, loadPresence, loadCompaction} = {4{64'h0000_0000_0000_0000}};
      errors = 0;
      samplesChecked = 0;
      doReset();
      load(64'h0000_0000_0000_0055, state_save_pkg::ALL_ZERO);
      foreach (rows[i])
      begin
         @(posedge clk_sys);
         {osSaveEnableBit, taskSwitchedFlag, alignmentMaskControl, flagsAlignmentCheckBit} <= rows[i][11:8];
         currentPrivilegeLevel <= rows[i][7:6];
         saveAreaAddr <= {BASE[63:6], rows[i][5:0]};
         op(1'b1, 1'b0, rows[i][15:12]);
      end
      op(1'b0, 1'b1, 4'h0);
      touch(64'h0000_0000_0000_0002, 64'h0000_0000_0000_0010);
      op(1'b1, 1'b0, 4'h0);
      @(posedge clk_sys);
      maskRegisterPair <= 64'h0000_0000_0000_0004;
      op(1'b1, 1'b0, 4'h0);
      // each of privilege, guest and address alone must veto the modified skip
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk_sys);
         currentPrivilegeLevel <= (k == 0) ? 2'h2 : 2'h3;
         virtualizedGuestMode  <= (k == 1);
         saveAreaAddr          <= (k == 2) ? BASE + 64'h0000_0000_0000_0040 : BASE;
         op(1'b1, 1'b0, 4'h0);
      end
      load(64'h8000_0000_0000_00F0, 64'h8000_0000_0000_00FF);
      saveAreaAddr <= BASE;
      maskRegisterPair <= ONES;
      op(1'b0, 1'b1, 4'h0);
      op(1'b1, 1'b0, 4'h0);
      load(64'h0000_0000_0000_000F, state_save_pkg::ALL_ZERO);
      maskRegisterPair <= state_save_pkg::ALL_ZERO;
      op(1'b0, 1'b1, 4'h0);
      @(posedge clk_sys);
      maskRegisterPair <= ONES;
      op(1'b1, 1'b0, 4'h0);
      op(1'b1, 1'b1, 4'h0);
      doReset();
      op(1'b1, 1'b0, 4'h0);
      printVerdict();
   end
endmodule
`default_nettype wire
